//--- design/acr_pkg.sv
// constants and register map of the core control register bank
package acr_pkg;

  // ******************************************************************
  // register addresses and pages
  // ******************************************************************
  localparam logic [7:0] ACR_ADDR_PAGE_SELECT  = 8'h00;
  localparam logic [7:0] ACR_ADDR_SOFT_RESET   = 8'h01;
  localparam logic [7:0] ACR_ADDR_MODE_CTRL    = 8'h02;
  localparam logic [7:0] ACR_ADDR_CHANNEL_CFG  = 8'h03;
  localparam logic [7:0] ACR_ADDR_LATE_INIT    = 8'h3e;
  localparam logic [7:0] ACR_PAGE_CORE         = 8'h00;
  localparam logic [7:0] ACR_PAGE_LATE_INIT    = 8'hfd;

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [7:0] ACR_RST_PAGE_SELECT   = 8'h00;
  localparam logic [7:0] ACR_RST_MODE_CTRL     = 8'h1a;
  localparam logic [7:0] ACR_RST_CHANNEL_CFG   = 8'h28;
  localparam logic [7:0] ACR_RST_LATE_INIT     = 8'h00;
  localparam logic [7:0] ACR_READ_ZERO         = 8'h00;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int ACR_SOFT_RESET_BIT            = 0;
  localparam int ACR_BROWNOUT_SRC_BIT          = 7;
  localparam int ACR_ISENSE_PD_BIT             = 4;
  localparam int ACR_VSENSE_PD_BIT             = 3;
  localparam int ACR_MODE_MSB                  = 2;
  localparam int ACR_MODE_LSB                  = 0;
  localparam int ACR_SUPPLY_MSB                = 7;
  localparam int ACR_SUPPLY_LSB                = 6;
  localparam int ACR_LEVEL_MSB                 = 5;
  localparam int ACR_LEVEL_LSB                 = 1;
  localparam logic [4:0] ACR_LEVEL_MAX         = 5'h14;

  // ******************************************************************
  // operating modes
  // ******************************************************************
  localparam logic [2:0] ACR_MODE_ACTIVE       = 3'h0;
  localparam logic [2:0] ACR_MODE_MUTED        = 3'h1;
  localparam logic [2:0] ACR_MODE_SHUTDOWN     = 3'h2;
  localparam logic [2:0] ACR_MODE_DIAG_POWERUP = 3'h3;
  localparam logic [2:0] ACR_MODE_DIAG_ALONE   = 3'h4;
  localparam logic [2:0] ACR_MODE_DIAG_GEN     = 3'h5;

  // output stage supply codes
  localparam logic [1:0] ACR_SUPPLY_DUAL_HIGH  = 2'h0;
  localparam logic [1:0] ACR_SUPPLY_BATTERY    = 2'h1;
  localparam logic [1:0] ACR_SUPPLY_HV         = 2'h2;
  localparam logic [1:0] ACR_SUPPLY_DUAL_LOW   = 2'h3;

endpackage : acr_pkg

//--- design/acr_core_regs.sv
// page-0 core control register bank with mode sequencing
`timescale 1ns/1ns
`default_nettype none
module acr_core_regs (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_diag_done,
  output var  logic [7:0] o_rdata,
  output var  logic       o_rd_valid,
  output var  logic [7:0] o_page,
  output var  logic       o_soft_reset,
  output var  logic [2:0] o_mode,
  output var  logic       o_brownout_input_select,
  output var  logic       o_current_sense_powerdown,
  output var  logic       o_voltage_sense_powerdown,
  output var  logic [1:0] o_output_stage_supply_select,
  output var  logic [4:0] o_amp_level,
  output var  logic [7:0] o_late_init_cfg,
  output var  logic       o_diag_run,
  output var  logic       o_amp_enable,
  output var  logic       o_amp_mute
);
  import acr_pkg::*;

  // ******************************************************************
  // state
  // ******************************************************************
  logic [7:0] page_select,  next_page_select;
  logic [7:0] mode_ctrl,    next_mode_ctrl;
  logic [7:0] chan_cfg,     next_chan_cfg;
  logic [7:0] late_init,    next_late_init;
  logic       diag_passed,  next_diag_passed;
  logic       soft_reset,   next_soft_reset;
  logic [7:0] rdata,        next_rdata;
  logic       rd_valid,     next_rd_valid;
  logic       diag_run,     next_diag_run;
  logic       amp_enable,   next_amp_enable;
  logic       amp_mute,     next_amp_mute;

  logic       on_core;
  logic       wr_page;
  logic       wr_mode;
  logic       wr_chan;
  logic       wr_late;
  logic       wr_soft;
  logic [2:0] mode_now;

  // ******************************************************************
  // decode
  // ******************************************************************
  always_comb begin
    on_core  = (page_select == ACR_PAGE_CORE);
    // page select answers on every page so software can always leave one
    wr_page  = i_wr_en && (i_addr == ACR_ADDR_PAGE_SELECT);
    // soft reset, mode and channel registers live on page 0 only
    wr_soft  = i_wr_en && on_core && (i_addr == ACR_ADDR_SOFT_RESET);
    wr_mode  = i_wr_en && on_core && (i_addr == ACR_ADDR_MODE_CTRL);
    wr_chan  = i_wr_en && on_core && (i_addr == ACR_ADDR_CHANNEL_CFG);
    // the late init register only answers on its own page
    wr_late  = i_wr_en && (page_select == ACR_PAGE_LATE_INIT) &&
               (i_addr == ACR_ADDR_LATE_INIT);
    mode_now = mode_ctrl[ACR_MODE_MSB:ACR_MODE_LSB];
  end

  // ******************************************************************
  // next register values
  // ******************************************************************
  always_comb begin
    next_page_select = page_select;
    next_mode_ctrl   = mode_ctrl;
    next_chan_cfg    = chan_cfg;
    next_late_init   = late_init;
    next_diag_passed = diag_passed;
    next_soft_reset  = wr_soft && i_wdata[ACR_SOFT_RESET_BIT];
    if (wr_page) begin
      next_page_select = i_wdata;
    end
    if (wr_chan) begin
      next_chan_cfg = i_wdata;
    end
    if (wr_late) begin
      next_late_init = i_wdata;
    end
    if (wr_mode) begin
      next_mode_ctrl   = i_wdata;
      // a fresh mode write re-arms the diagnostics of mode 011b
      next_diag_passed = 1'b0;
    end
    // hardware completion wins over a host write in the same cycle
    if (i_diag_done && diag_run) begin
      if (mode_now == ACR_MODE_DIAG_ALONE) begin
        next_mode_ctrl[ACR_MODE_MSB:ACR_MODE_LSB] = ACR_MODE_SHUTDOWN;
        next_diag_passed = 1'b0;
      end else begin
        next_diag_passed = 1'b1;
      end
    end
    // soft reset wins over everything, so writes during its pulse are lost
    if (soft_reset) begin
      next_page_select = ACR_RST_PAGE_SELECT;
      next_mode_ctrl   = ACR_RST_MODE_CTRL;
      next_chan_cfg    = ACR_RST_CHANNEL_CFG;
      next_late_init   = ACR_RST_LATE_INIT;
      next_diag_passed = 1'b0;
      next_soft_reset  = 1'b0;
    end
  end

  // ******************************************************************
  // read path and derived controls
  // ******************************************************************
  always_comb begin
    // a read in the same cycle as a write returns the value held before it
    next_rd_valid = i_rd_en;
    next_rdata    = ACR_READ_ZERO;
    if (i_rd_en) begin
      if (i_addr == ACR_ADDR_PAGE_SELECT) begin
        next_rdata = page_select;
      end else if (on_core && (i_addr == ACR_ADDR_MODE_CTRL)) begin
        next_rdata = mode_ctrl;
      end else if (on_core && (i_addr == ACR_ADDR_CHANNEL_CFG)) begin
        next_rdata = chan_cfg;
      end else if ((page_select == ACR_PAGE_LATE_INIT) &&
                   (i_addr == ACR_ADDR_LATE_INIT)) begin
        next_rdata = late_init;
      end
      // soft reset register and unmapped addresses read as zero
    end
    next_diag_run   = 1'b0;
    next_amp_enable = 1'b0;
    next_amp_mute   = 1'b0;
    case (next_mode_ctrl[ACR_MODE_MSB:ACR_MODE_LSB])
      ACR_MODE_ACTIVE: begin
        next_amp_enable = 1'b1;
      end
      ACR_MODE_MUTED: begin
        next_amp_enable = 1'b1;
        next_amp_mute   = 1'b1;
      end
      ACR_MODE_DIAG_POWERUP: begin
        next_diag_run   = !next_diag_passed;
        next_amp_enable = next_diag_passed;
      end
      ACR_MODE_DIAG_ALONE: begin
        next_diag_run = 1'b1;
      end
      ACR_MODE_SHUTDOWN: begin
        next_amp_enable = 1'b0;
      end
      ACR_MODE_DIAG_GEN: begin
        // generator mode feeds its own test signal, the amplifier stays off
        next_amp_enable = 1'b0;
      end
      default: begin
        // reserved codes 110b and 111b leave every control off
        next_diag_run = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // register bank state
  // ******************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      page_select <= ACR_RST_PAGE_SELECT;
      mode_ctrl   <= ACR_RST_MODE_CTRL;
      chan_cfg    <= ACR_RST_CHANNEL_CFG;
      late_init   <= ACR_RST_LATE_INIT;
      diag_passed <= 1'b0;
      soft_reset  <= 1'b0;
    end else begin
      page_select <= next_page_select;
      mode_ctrl   <= next_mode_ctrl;
      chan_cfg    <= next_chan_cfg;
      late_init   <= next_late_init;
      diag_passed <= next_diag_passed;
      soft_reset  <= next_soft_reset;
    end
  end

  // ******************************************************************
  // read answer and derived control state
  // ******************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata       <= ACR_READ_ZERO;
      rd_valid    <= 1'b0;
      diag_run    <= 1'b0;
      amp_enable  <= 1'b0;
      amp_mute    <= 1'b0;
    end else begin
      rdata       <= next_rdata;
      rd_valid    <= next_rd_valid;
      diag_run    <= next_diag_run;
      amp_enable  <= next_amp_enable;
      amp_mute    <= next_amp_mute;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  always_comb begin
    o_rdata                      = rdata;
    o_rd_valid                   = rd_valid;
    o_page                       = page_select;
    o_soft_reset                 = soft_reset;
    o_mode                       = mode_ctrl[ACR_MODE_MSB:ACR_MODE_LSB];
    o_brownout_input_select      = mode_ctrl[ACR_BROWNOUT_SRC_BIT];
    o_current_sense_powerdown    = mode_ctrl[ACR_ISENSE_PD_BIT];
    o_voltage_sense_powerdown    = mode_ctrl[ACR_VSENSE_PD_BIT];
    o_output_stage_supply_select = chan_cfg[ACR_SUPPLY_MSB:ACR_SUPPLY_LSB];
    o_amp_level                  = chan_cfg[ACR_LEVEL_MSB:ACR_LEVEL_LSB];
    o_late_init_cfg              = late_init;
    o_diag_run                   = diag_run;
    o_amp_enable                 = amp_enable;
    o_amp_mute                   = amp_mute;
  end

endmodule // acr_core_regs
`default_nettype wire

//--- dv/acr_diag_model.sv
// load-diagnostics engine model that answers the diagnostics request
`timescale 1ns/1ns
`default_nettype none
module acr_diag_model #(
  parameter int DELAY = 20
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_diag_run,
  output wire logic o_diag_done
);
  // ******
  // run timer
  // ******
  int cnt = 0;
  // restarts whenever the request drops; a mode rewrite that keeps the request high does not start over
  always @(posedge i_sys_clk)
    cnt <= (i_reset || !i_diag_run || cnt == DELAY) ? 0 : cnt + 1;
  assign o_diag_done = (cnt == DELAY);
endmodule // acr_diag_model
`default_nettype wire

//--- dv/acr_core_regs_properties.sv
// assertion checker for the core control register bank
`timescale 1ns/1ns
`default_nettype none
module acr_core_regs_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_diag_done,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_page,
  input wire logic       o_soft_reset,
  input wire logic [2:0] o_mode,
  input wire logic       o_diag_run,
  input wire logic       o_amp_enable
);
  import acr_pkg::*;
  // ******
  // properties
  // ******
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_cw(a);
    i_wr_en && !o_soft_reset && o_page == ACR_PAGE_CORE && i_addr == a;
  endsequence
  sequence s_done(m);
    o_diag_run && i_diag_done && !o_soft_reset && o_mode == m;
  endsequence
  property p_page_wr;
    i_wr_en && !o_soft_reset && i_addr == ACR_ADDR_PAGE_SELECT |=> o_page == $past(i_wdata);
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write lost");
  property p_rst;
    $past(i_reset) |-> o_page == ACR_RST_PAGE_SELECT && o_mode == ACR_MODE_SHUTDOWN;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_sr_one;
    s_cw(ACR_ADDR_SOFT_RESET) ##0 i_wdata[0] |=> o_soft_reset ##1 (!o_soft_reset &&
      o_page == ACR_RST_PAGE_SELECT && o_mode == ACR_MODE_SHUTDOWN);
  endproperty
  a_sr_one: assert property (p_sr_one) else $error("soft reset wrong");
  property p_sr_zero;
    s_cw(ACR_ADDR_SOFT_RESET) ##0 !i_wdata[0] |=> !o_soft_reset;
  endproperty
  a_sr_zero: assert property (p_sr_zero) else $error("zero write reset");
  property p_rd_zero;
    i_rd_en && !o_soft_reset && o_page == ACR_PAGE_CORE && i_addr == ACR_ADDR_SOFT_RESET
      |=> o_rd_valid && o_rdata == ACR_READ_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reset reg not zero");
  property p_mode4;
    s_cw(ACR_ADDR_MODE_CTRL) ##0 (i_wdata[2:0] == ACR_MODE_DIAG_ALONE && !i_diag_done)
      |=> o_mode == ACR_MODE_DIAG_ALONE && o_diag_run;
  endproperty
  a_mode4: assert property (p_mode4) else $error("diag not started");
  property p_diag4;
    s_done(ACR_MODE_DIAG_ALONE) |=> o_mode == ACR_MODE_SHUTDOWN && !o_diag_run;
  endproperty
  a_diag4: assert property (p_diag4) else $error("no return to shutdown");
  property p_diag3;
    s_done(ACR_MODE_DIAG_POWERUP) ##0 !i_wr_en |=> o_amp_enable && !o_diag_run;
  endproperty
  a_diag3: assert property (p_diag3) else $error("no power up");
endmodule // acr_core_regs_chk
bind acr_core_regs acr_core_regs_chk u_chk (
  .i_sys_clk    (i_sys_clk),
  .i_reset      (i_reset),
  .i_wr_en      (i_wr_en),
  .i_rd_en      (i_rd_en),
  .i_addr       (i_addr),
  .i_wdata      (i_wdata),
  .i_diag_done  (i_diag_done),
  .o_rdata      (o_rdata),
  .o_rd_valid   (o_rd_valid),
  .o_page       (o_page),
  .o_soft_reset (o_soft_reset),
  .o_mode       (o_mode),
  .o_diag_run   (o_diag_run),
  .o_amp_enable (o_amp_enable)
);
`default_nettype wire

//--- dv/tb_top.sv
// testbench for the core control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import acr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       we  = 1'b0;
  logic       re  = 1'b0;
  logic [7:0] ad  = 8'h00;
  logic [7:0] wd  = 8'h00;
  logic [7:0] rdat, page, lic;
  logic [4:0] lvl;
  logic [2:0] mode;
  logic [1:0] sup;
  logic       dd, rv, sr, bo, isn, vsn, run, en, mu;
  int         err_total = 0;
  int         checks_done = 0;
  localparam logic [19:0] LV = {5'h13, 5'h0a, 5'h14, 5'h00};
  localparam logic [17:0] ST = 18'h0_1234;
  acr_core_regs u_dut (.i_sys_clk(clk), .i_reset(rst), .i_wr_en(we), .i_rd_en(re),
    .i_addr(ad), .i_wdata(wd), .i_diag_done(dd), .o_rdata(rdat), .o_rd_valid(rv),
    .o_page(page), .o_soft_reset(sr), .o_mode(mode), .o_brownout_input_select(bo),
    .o_current_sense_powerdown(isn), .o_voltage_sense_powerdown(vsn),
    .o_output_stage_supply_select(sup), .o_amp_level(lvl), .o_late_init_cfg(lic),
    .o_diag_run(run), .o_amp_enable(en), .o_amp_mute(mu));
  acr_diag_model u_diag (.i_sys_clk(clk), .i_reset(rst), .i_diag_run(run), .o_diag_done(dd));
  // ******
  // access tasks
  // ******
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    ad <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk("rd_valid", 8'h01, {7'h00, rv});
    chk("rdata", e, rdat);
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 60 && run !== 1'b0; k++) @(posedge clk);
    #1;
    chk("diag_run", 8'h00, {7'h00, run});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h1a);
    rd(8'h03, 8'h28);
    chk("mode_out", 8'h1a, {bo, 2'b00, isn, vsn, mode});
    chk("chan_out", 8'h28, {sup, lvl, 1'b0});
    wr(8'h00, 8'hfd);
    chk("page", 8'hfd, page);
    rd(8'h02, 8'h00);
    wr(8'h3e, 8'ha5);
    wr(8'h03, 8'h00);
    rd(8'h3e, 8'ha5);
    chk("late_init", 8'ha5, lic);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hff);
    wr(8'h00, 8'h00);
    rd(8'h03, 8'h28);
    wr(8'h03, 8'hc8);
    wr(8'h01, 8'h00);
    chk("soft_reset", 8'h00, {7'h00, sr});
    rd(8'h03, 8'hc8);
    wr(8'h01, 8'h01);
    chk("soft_reset", 8'h01, {7'h00, sr});
    rd(8'h02, 8'h1a);
    chk("soft_reset", 8'h00, {7'h00, sr});
    rd(8'h03, 8'h28);
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, {i[1:0], LV[i*5+:5], 1'b0});
      chk("chan_out", {i[1:0], LV[i*5+:5], 1'b0}, {sup, lvl, 1'b0});
    end
    for (int m = 0; m < 6; m++) begin
      wr(8'h02, 8'h80 | m[7:0]);
      chk("mode_out", 8'h80 | m[7:0], {bo, 2'b00, isn, vsn, mode});
      chk("amp_state", {5'h00, ST[m*3+:3]}, {5'h00, en, mu, run});
    end
    wr(8'h02, 8'h04);
    wait_idle;
    rd(8'h02, 8'h02);
    wr(8'h02, 8'h03);
    wait_idle;
    chk("amp_state", 8'h04, {5'h00, en, mu, run});
    rd(8'h02, 8'h03);
    conclude;
  end
endmodule // tb_top
`default_nettype wire
